// file: core/scr_pkg.sv
// Functional notes
// - sync nine-bit: latch I/O at ninth edge
// - final byte: check CRC 1D0F or LRC 0
// - read-only check error status bit
// - full bit high while queue full
// - empty bit never raises an interrupt
// - byte into full queue sets overrun, error
// - after overrun drop bytes until status read
// - parity error flag, clear on read, error
// - queue bytes, oldest out at data port
// - outside sync: control one drives reset low
// - reset control bit works in all modes
// - sync: reset bit non-inverted, length ignored
// - outside sync: line bit reads present I/O level
// - bypass: written line bit drives I/O
// - sync: line bit holds last edge sample
// - direction one input, zero output (default)
// - clock stop holds level, also in bypass
package scr_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] ADDR_RX_STATUS = 16'hFE08;
  localparam logic [15:0] ADDR_RX_DATA = 16'hFE09;
  localparam logic [15:0] ADDR_CARD_CTL = 16'hFE0A;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFE10;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hFE11;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hFE12;
  localparam logic [7:0] CARD_CTL_RESET = 8'h21;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_COUNT_FULL = 3'h4;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
  localparam logic [7:0] LRC_RESIDUE = 8'h00;
  localparam logic [3:0] NINTH_EDGE = 4'h9;
  localparam logic [3:0] EIGHTH_EDGE = 4'h8;
  // rx status bit positions
  localparam int unsigned ST_NINTH = 7;
  localparam int unsigned ST_FINAL = 5;
  localparam int unsigned ST_CHECK = 4;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_EMPTY = 2;
  localparam int unsigned ST_OVR = 1;
  localparam int unsigned ST_PAR = 0;
  // card control bit positions
  localparam int unsigned CC_RST = 7;
  localparam int unsigned CC_IO = 5;
  localparam int unsigned CC_DIR = 4;
  localparam int unsigned CC_C8 = 3;
  localparam int unsigned CC_C4 = 2;
  localparam int unsigned CC_LVL = 1;
  localparam int unsigned CC_STOP = 0;
  // interrupt bit positions
  localparam int unsigned IRQ_DATA = 0;
  localparam int unsigned IRQ_ERR = 1;
  localparam int unsigned IRQ_CHECK = 2;

  typedef enum logic [1:0] {mode_normal, mode_auto, mode_sync, mode_bypass} scr_mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scr_bus_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity_bad;
  } scr_rx_byte_type;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] count;
    logic ovr;
    logic par;
    logic check_err;
    logic final_rx_byte_flag;
    logic ninth_bit_sample;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic [7:0] card_ctl;
    logic io_sampled;
    logic [1:0] io_sync;
    logic [2:0] clk_sync;
    logic [3:0] edge_count;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic irq;
    logic [7:0] rd_data;
    logic card_rst_out;
    logic card_io_out;
    logic card_io_oe;
    logic card_clk_out;
  } scr_state_type;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
endpackage

// file: core/scr_card_rx.sv
`timescale 1ns/1ps
`default_nettype none
module scr_card_rx (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire scr_pkg::scr_bus_type bus, // register access request
  output logic [7:0] bus_rdata, // read data, cycle after read
  input wire scr_pkg::scr_rx_byte_type rx_byte, // byte from card receiver
  input wire logic crc_restart, // pulse: new message, restart check
  input wire logic check_is_crc, // 1 crc, 0 lrc
  input wire scr_pkg::scr_mode_type mode, // card protocol mode
  input wire logic nine_bit_format_select, // sync nine-bit format
  input wire logic seq_rst_level, // reset level from activation sequencer
  input wire logic clk_gen, // free card clock from divider
  input wire logic card_io_in, // card I/O pin level
  input wire logic card_clk_in, // card clock pin level
  output logic card_rst_out, // card reset pin
  output logic card_io_out, // card I/O drive level
  output logic card_io_oe, // card I/O output enable
  output logic card_clk_out, // card clock pin
  output logic irq // level interrupt
);
  scr_pkg::scr_state_type s;
  scr_pkg::scr_state_type next_s;

  logic rd_status;
  logic rd_data_port;
  logic full;
  logic empty;
  logic clk_rise;
  logic [15:0] crc_new;
  logic [7:0] lrc_new;
  logic check_fail;
  logic line_read;
  logic set_data;
  logic set_err;
  logic set_check;

  always_comb begin
    rd_status = bus.rd && bus.addr == scr_pkg::ADDR_RX_STATUS;
    rd_data_port = bus.rd && bus.addr == scr_pkg::ADDR_RX_DATA;
    full = s.count == scr_pkg::FIFO_COUNT_FULL;
    empty = s.count == 3'h0;
    // second and third stage only; first stage feeds nothing else
    clk_rise = s.clk_sync[1] && !s.clk_sync[2];
    crc_new = scr_pkg::crc_step(s.crc, rx_byte.data);
    lrc_new = s.lrc ^ rx_byte.data;
    check_fail = check_is_crc ? (crc_new != scr_pkg::CRC_RESIDUE) :
                 (lrc_new != scr_pkg::LRC_RESIDUE);
    // sync mode shows the edge sample, otherwise the live line
    line_read = (mode == scr_pkg::mode_sync) ? s.io_sampled : s.io_sync[1];
    set_data = rx_byte.valid && !full && !s.ovr;
    set_err = rx_byte.valid && (full || rx_byte.parity_bad);
    set_check = rx_byte.valid && s.final_rx_byte_flag && check_fail;
  end

  always_comb begin
    next_s = s;
    next_s.io_sync = {s.io_sync[0], card_io_in};
    next_s.clk_sync = {s.clk_sync[1:0], card_clk_in};

    // receive queue
    if (set_data) begin
      next_s.mem[s.wr_ptr] = rx_byte.data;
      next_s.wr_ptr = s.wr_ptr + 2'h1;
    end
    if (rd_data_port && !empty) begin
      next_s.rd_ptr = s.rd_ptr + 2'h1;
    end
    next_s.count = s.count + {2'h0, set_data} - {2'h0, rd_data_port && !empty};

    // sticky flags: a read clears, a same-cycle event wins
    if (rd_status) begin
      next_s.ovr = 1'b0;
      next_s.par = 1'b0;
      next_s.check_err = 1'b0;
    end
    if (rx_byte.valid && full) begin
      next_s.ovr = 1'b1;
    end
    if (rx_byte.valid && rx_byte.parity_bad) begin
      next_s.par = 1'b1;
    end
    if (set_check) begin
      next_s.check_err = 1'b1;
    end

    // running check over the message
    if (crc_restart) begin
      next_s.crc = scr_pkg::CRC_INIT;
      next_s.lrc = 8'h00;
    end else if (rx_byte.valid) begin
      next_s.crc = crc_new;
      next_s.lrc = lrc_new;
    end

    // sync mode bit sampling on card clock rising edges
    if (mode != scr_pkg::mode_sync) begin
      next_s.edge_count = 4'h0;
    end else if (clk_rise) begin
      next_s.io_sampled = s.io_sync[1];
      if ((nine_bit_format_select && s.edge_count == scr_pkg::EIGHTH_EDGE) ||
          (!nine_bit_format_select && s.edge_count == 4'h7)) begin
        next_s.edge_count = 4'h0;
      end else begin
        next_s.edge_count = s.edge_count + 4'h1;
      end
      if (nine_bit_format_select && s.edge_count + 4'h1 == scr_pkg::NINTH_EDGE) begin
        next_s.ninth_bit_sample = s.io_sync[1];
      end
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        scr_pkg::ADDR_RX_STATUS: next_s.final_rx_byte_flag = bus.wdata[scr_pkg::ST_FINAL];
        scr_pkg::ADDR_CARD_CTL: next_s.card_ctl = bus.wdata;
        scr_pkg::ADDR_IRQ_CLEAR: next_s.irq_stat = s.irq_stat & ~bus.wdata[2:0];
        scr_pkg::ADDR_IRQ_ENABLE: next_s.irq_en = bus.wdata[2:0];
        default: next_s.card_ctl = s.card_ctl;
      endcase
    end

    // interrupt events; empty status is not a source
    if (set_data) begin
      next_s.irq_stat[scr_pkg::IRQ_DATA] = 1'b1;
    end
    if (set_err) begin
      next_s.irq_stat[scr_pkg::IRQ_ERR] = 1'b1;
    end
    if (set_check) begin
      next_s.irq_stat[scr_pkg::IRQ_CHECK] = 1'b1;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);

    // read data, one cycle after the strobe
    next_s.rd_data = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        scr_pkg::ADDR_RX_STATUS: begin
          next_s.rd_data[scr_pkg::ST_NINTH] = s.ninth_bit_sample;
          next_s.rd_data[scr_pkg::ST_FINAL] = s.final_rx_byte_flag;
          next_s.rd_data[scr_pkg::ST_CHECK] = s.check_err;
          next_s.rd_data[scr_pkg::ST_FULL] = full;
          next_s.rd_data[scr_pkg::ST_EMPTY] = empty;
          next_s.rd_data[scr_pkg::ST_OVR] = s.ovr;
          next_s.rd_data[scr_pkg::ST_PAR] = s.par;
        end
        scr_pkg::ADDR_RX_DATA: next_s.rd_data = empty ? 8'h00 : s.mem[s.rd_ptr];
        scr_pkg::ADDR_CARD_CTL: begin
          next_s.rd_data = s.card_ctl;
          next_s.rd_data[6] = 1'b0;
          next_s.rd_data[scr_pkg::CC_IO] = line_read;
        end
        scr_pkg::ADDR_IRQ_STATUS: next_s.rd_data = {5'h00, s.irq_stat};
        scr_pkg::ADDR_IRQ_ENABLE: next_s.rd_data = {5'h00, s.irq_en};
        default: next_s.rd_data = 8'h00;
      endcase
    end

    // card reset line; the control bit acts in every mode
    unique case (mode)
      scr_pkg::mode_sync: next_s.card_rst_out = s.card_ctl[scr_pkg::CC_RST];
      scr_pkg::mode_auto: next_s.card_rst_out =
          !s.card_ctl[scr_pkg::CC_RST] && seq_rst_level;
      default: next_s.card_rst_out = !s.card_ctl[scr_pkg::CC_RST];
    endcase

    // card I/O drive; other modes leave the pin to the transmitter
    if (mode == scr_pkg::mode_bypass || mode == scr_pkg::mode_sync) begin
      next_s.card_io_oe = !s.card_ctl[scr_pkg::CC_DIR];
      next_s.card_io_out = s.card_ctl[scr_pkg::CC_IO];
    end else begin
      next_s.card_io_oe = 1'b0;
      next_s.card_io_out = 1'b0;
    end

    // card clock; bypass drives the level bit directly
    if (mode == scr_pkg::mode_bypass || s.card_ctl[scr_pkg::CC_STOP]) begin
      next_s.card_clk_out = s.card_ctl[scr_pkg::CC_LVL];
    end else begin
      next_s.card_clk_out = clk_gen;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
      s.card_ctl <= scr_pkg::CARD_CTL_RESET;
      s.crc <= scr_pkg::CRC_INIT;
      s.card_rst_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata = s.rd_data;
  assign card_rst_out = s.card_rst_out;
  assign card_io_out = s.card_io_out;
  assign card_io_oe = s.card_io_oe;
  assign card_clk_out = s.card_clk_out;
  assign irq = s.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ninth_bit_capture_a: assert property (
    mode == scr_pkg::mode_sync && $past(mode) == scr_pkg::mode_sync && nine_bit_format_select
    && clk_rise && s.edge_count == scr_pkg::EIGHTH_EDGE
    |=> s.ninth_bit_sample == $past(s.io_sync[1]))
    else $error("ninth bit not captured at ninth edge");

  check_error_set_a: assert property (
    rx_byte.valid && s.final_rx_byte_flag
    && (check_is_crc ? scr_pkg::crc_step(s.crc, rx_byte.data) != scr_pkg::CRC_RESIDUE
        : (s.lrc ^ rx_byte.data) != scr_pkg::LRC_RESIDUE)
    |=> s.check_err)
    else $error("check mismatch not flagged");

  full_status_a: assert property (
    rd_status |=> bus_rdata[scr_pkg::ST_FULL] == ($past(s.count) == scr_pkg::FIFO_COUNT_FULL))
    else $error("full bit does not match queue level");

  empty_no_irq_a: assert property (
    !rx_byte.valid && !(bus.wr && bus.addr == scr_pkg::ADDR_IRQ_ENABLE)
    |=> $stable(s.irq_stat[scr_pkg::IRQ_DATA]) || !s.irq_stat[scr_pkg::IRQ_DATA])
    else $error("data interrupt raised without a byte");

  overrun_set_a: assert property (
    rx_byte.valid && full |=> s.ovr && s.irq_stat[scr_pkg::IRQ_ERR])
    else $error("overrun not flagged");

  overrun_drop_a: assert property (
    s.ovr && rx_byte.valid |=> $stable(s.wr_ptr))
    else $error("byte written during overrun");

  parity_clear_a: assert property (
    rd_status && !(rx_byte.valid && rx_byte.parity_bad) |=> !s.par)
    else $error("parity flag not cleared by read");

  data_port_read_a: assert property (
    rd_data_port && !empty |=> bus_rdata == $past(s.mem[s.rd_ptr]))
    else $error("oldest byte not returned");

  reset_sense_a: assert property (
    $past(mode) == scr_pkg::mode_sync && $stable(s.card_ctl)
    |-> card_rst_out == s.card_ctl[scr_pkg::CC_RST])
    else $error("sync reset not non-inverted");

  normal_reset_a: assert property (
    mode == scr_pkg::mode_normal && s.card_ctl[scr_pkg::CC_RST] |=> !card_rst_out)
    else $error("reset not asserted low");

  bypass_drive_a: assert property (
    mode == scr_pkg::mode_bypass && !s.card_ctl[scr_pkg::CC_DIR]
    |=> card_io_oe && card_io_out == $past(s.card_ctl[scr_pkg::CC_IO]))
    else $error("bypass line not driven");

  clock_stop_a: assert property (
    s.card_ctl[scr_pkg::CC_STOP] |=> card_clk_out == $past(s.card_ctl[scr_pkg::CC_LVL]))
    else $error("clock not held at stop level");
endmodule
`default_nettype wire

// file: verif/scr_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module scr_card_model (
  output logic io_drv, // level the card puts on I/O
  output logic io_en, // high while the card drives I/O
  output logic clk_pin // card clock, still between frames
);
  initial begin
    io_drv = 1'b0;
    io_en = 1'b0;
    clk_pin = 1'b0;
  end
  // lsb first, one bit per 320 ns clock period
  task automatic frame(input logic [8:0] bits);
    // start off the system clock edge so pin changes never race it
    #10 io_en = 1'b1;
    for (int i = 0; i < 9; i++) begin
      io_drv = bits[i];
      #160 clk_pin = 1'b1;
      #160 clk_pin = 1'b0;
    end
    // released line goes to the pull-up, stale value inverted
    io_en = 1'b0;
    io_drv = ~io_drv;
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  localparam logic [15:0] A_ST = scr_pkg::ADDR_RX_STATUS;
  localparam logic [15:0] A_DT = scr_pkg::ADDR_RX_DATA;
  localparam logic [15:0] A_CC = scr_pkg::ADDR_CARD_CTL;
  localparam logic [15:0] A_IS = scr_pkg::ADDR_IRQ_STATUS;
  localparam logic [15:0] A_IC = scr_pkg::ADDR_IRQ_CLEAR;
  localparam logic [15:0] A_IE = scr_pkg::ADDR_IRQ_ENABLE;
  logic clk_sys, sys_rst, crc_restart, check_is_crc, nine_sel, seq_lvl, clk_gen;
  scr_pkg::scr_bus_type bus;
  scr_pkg::scr_rx_byte_type rx_byte;
  scr_pkg::scr_mode_type mode;
  logic [7:0] bus_rdata, v;
  logic card_rst_out, card_io_out, card_io_oe, card_clk_out, irq, io_drv, io_en, card_clk_in;
  wire logic card_io_in;
  int fail_count, checks_done;
  scr_pkg::scr_mode_type md [6];
  logic [7:0] cv [6];
  logic ex [6];
  // released line floats high through the pull-up
  assign card_io_in = card_io_oe ? card_io_out : (io_en ? io_drv : 1'b1);

  scr_card_rx i_scr_card_rx (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
    .bus_rdata(bus_rdata), .rx_byte(rx_byte), .crc_restart(crc_restart),
    .check_is_crc(check_is_crc), .mode(mode), .nine_bit_format_select(nine_sel),
    .seq_rst_level(seq_lvl), .clk_gen(clk_gen), .card_io_in(card_io_in),
    .card_clk_in(card_clk_in), .card_rst_out(card_rst_out), .card_io_out(card_io_out),
    .card_io_oe(card_io_oe), .card_clk_out(card_clk_out), .irq(irq));
  scr_card_model i_scr_card_model (.io_drv(io_drv), .io_en(io_en), .clk_pin(card_clk_in));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    clk_gen = 1'b0;
    forever @(posedge clk_sys) clk_gen <= ~clk_gen;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(posedge clk_sys);
    d = bus_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string n);
    rd(a, v);
    `CHK(n, e, v)
  endtask
  task automatic push(input logic [7:0] d, input logic pb);
    @(posedge clk_sys);
    rx_byte <= '{valid: 1'b1, data: d, parity_bad: pb};
    @(posedge clk_sys);
    rx_byte.valid <= 1'b0;
  endtask
  task automatic restart;
    @(posedge clk_sys);
    crc_restart <= 1'b1;
    @(posedge clk_sys);
    crc_restart <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // guards against a hang anywhere in the sequence
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  initial begin
    bus = '0; rx_byte = '0; crc_restart = 1'b0; check_is_crc = 1'b0;
    nine_sel = 1'b0; seq_lvl = 1'b0; mode = scr_pkg::mode_normal; sys_rst = 1'b1;
    fail_count = 0; checks_done = 0; v = 8'h00;
    md = '{scr_pkg::mode_normal, scr_pkg::mode_normal, scr_pkg::mode_sync,
      scr_pkg::mode_sync, scr_pkg::mode_auto, scr_pkg::mode_auto};
    cv = '{8'h90, 8'h10, 8'h90, 8'h10, 8'h10, 8'h90};
    ex = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    cyc(6);
    sys_rst <= 1'b0;
    `CHK("rst pin", 1'b1, card_rst_out)
    // line synchroniser needs two edges before the pull-up level shows
    cyc(2);
    rdc(A_CC, 8'h21, "ctl reset");
    rdc(A_ST, 8'h04, "status reset");
    rdc(A_DT, 8'h00, "empty pop");
    rdc(16'hFE0F, 8'h00, "unmapped");
    $display("test reset done");
    wr(A_IE, 8'h01);
    for (int i = 0; i < 4; i++) push(8'hA0 + 8'(i), 1'b0);
    cyc(1);
    `CHK("irq data", 1'b1, irq)
    rdc(A_ST, 8'h08, "full");
    push(8'hEE, 1'b0);
    rdc(A_DT, 8'hA0, "oldest");
    push(8'hEF, 1'b0);
    rdc(A_ST, 8'h02, "overrun");
    rdc(A_IS, 8'h03, "err event");
    for (int i = 1; i < 4; i++) rdc(A_DT, 8'hA0 + 8'(i), "fifo order");
    rdc(A_DT, 8'h00, "dropped");
    rdc(A_ST, 8'h04, "ovr cleared");
    wr(A_IC, 8'h07);
    $display("test fifo done");
    wr(A_IE, 8'h00);
    push(8'h33, 1'b1);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    rdc(A_IS, 8'h03, "parity event");
    wr(A_IE, 8'h02);
    cyc(2);
    `CHK("irq err", 1'b1, irq)
    wr(A_IC, 8'h07);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    rdc(A_ST, 8'h01, "parity");
    rdc(A_ST, 8'h00, "parity clr");
    rd(A_DT, v);
    $display("test parity done");
    restart();
    push(8'h5A, 1'b0);
    wr(A_ST, 8'h20);
    push(8'h5A, 1'b0);
    rd(A_ST, v);
    `CHK("lrc good", 1'b0, v[4])
    wr(A_ST, 8'h00);
    restart();
    wr(A_ST, 8'h20);
    push(8'hA5, 1'b0);
    rd(A_ST, v);
    `CHK("lrc bad", 1'b1, v[4])
    wr(A_ST, 8'h00);
    repeat (3) rd(A_DT, v);
    // two zero bytes from the initial value leave the good residue
    check_is_crc <= 1'b1;
    restart();
    push(8'h00, 1'b0);
    wr(A_ST, 8'h20);
    push(8'h00, 1'b0);
    rd(A_ST, v);
    `CHK("crc good", 1'b0, v[4])
    restart();
    push(8'h00, 1'b0);
    rd(A_ST, v);
    `CHK("crc bad", 1'b1, v[4])
    wr(A_ST, 8'h00);
    check_is_crc <= 1'b0;
    repeat (3) rd(A_DT, v);
    $display("test check done");
    seq_lvl <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      mode <= md[i];
      wr(A_CC, cv[i]);
      cyc(2);
      `CHK("rst pin", ex[i], card_rst_out)
    end
    wr(A_CC, 8'h10);
    seq_lvl <= 1'b0;
    cyc(2);
    `CHK("seq rst", 1'b0, card_rst_out)
    $display("test reset pin done");
    mode <= scr_pkg::mode_bypass;
    wr(A_CC, 8'h20);
    cyc(2);
    `CHK("io oe", 1'b1, card_io_oe)
    `CHK("io high", 1'b1, card_io_out)
    wr(A_CC, 8'h00);
    cyc(4);
    `CHK("io low", 1'b0, card_io_out)
    rd(A_CC, v);
    `CHK("line low", 1'b0, v[5])
    wr(A_CC, 8'h10);
    cyc(4);
    `CHK("io in", 1'b0, card_io_oe)
    rd(A_CC, v);
    `CHK("line up", 1'b1, v[5])
    $display("test bypass done");
    mode <= scr_pkg::mode_normal;
    for (int l = 0; l < 2; l++) begin
      wr(A_CC, 8'h11 | 8'(l << 1));
      cyc(2);
      repeat (3) begin
        cyc(1);
        `CHK("clk stopped", l[0], card_clk_out)
      end
    end
    wr(A_CC, 8'h10);
    cyc(3);
    v[0] = card_clk_out;
    cyc(1);
    `CHK("clk runs", ~v[0], card_clk_out)
    $display("test clock done");
    mode <= scr_pkg::mode_sync;
    nine_sel <= 1'b1;
    cyc(4);
    i_scr_card_model.frame(9'h100);
    cyc(6);
    rd(A_ST, v);
    `CHK("ninth one", 1'b1, v[7])
    i_scr_card_model.frame(9'h0FF);
    cyc(6);
    rd(A_ST, v);
    `CHK("ninth zero", 1'b0, v[7])
    rd(A_CC, v);
    `CHK("line sample", 1'b0, v[5])
    $display("test sync done");
    complete_run();
  end
endmodule
`default_nettype wire
